/* File: src/cacf_pkg.sv */
package cacf_pkg;
	localparam int NPORT = 8;
	localparam int PORT_W = 3;
	localparam int QU_W = 3;
	localparam int NQUEUE = 8;
	localparam int FOLD_W = 468;

	// Register byte offsets
	localparam logic [7:0] OFS_AGGR = 8'h00;
	localparam logic [7:0] OFS_PROTO_QU = 8'h04;
	localparam logic [7:0] OFS_RSV_QU = 8'h08;
	localparam logic [7:0] OFS_RRA_CFG = 8'h0C;
	localparam logic [7:0] OFS_RRA_VAL = 8'h10;
	localparam logic [7:0] OFS_RRA_MASK = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [2:0] OFS_CAP_SEL = 3'h2;
	localparam logic [0:0] OFS_ACT_SEL = 1'h1;

	// aggregation_code_config fields
	localparam int AG_DMAC = 0;
	localparam int AG_DMAC_REV = 1;
	localparam int AG_SMAC = 2;
	localparam int AG_FLOW = 3;
	localparam int AG_IP = 4;
	localparam int AG_L4 = 5;
	localparam int AG_INGRESS_SERVICE_INDEX = 6;
	localparam int AG_RND = 7;
	localparam int AG_STACK = 8;
	localparam int AG_W = 9;

	// cpu_protocol_queue_config fields, three bits each
	localparam int PQ_IGMP = 0;
	localparam int PQ_MLD = 3;
	localparam int PQ_HBH = 6;
	localparam int PQ_V4MC = 9;
	localparam int PQ_V6MC = 12;
	localparam int PQ_RRA = 15;
	localparam int PQ_W = 18;

	// cpu_reserved_addr_queue_config width, three groups of three bits
	localparam int RQ_W = 9;

	// Remote register access config fields
	localparam int RC_VID = 0;
	localparam int RC_AWARE = 12;
	localparam int RC_W = 13;

	// Per-port capture config fields
	localparam int CP_IGMP = 0;
	localparam int CP_MLD = 1;
	localparam int CP_HBH = 2;
	localparam int CP_ICMP = 3;
	localparam int CP_MCC = 4;
	localparam int CP_RRA = 5;
	localparam int CP_TPID = 8;
	localparam int CP_W = 13;

	// Reset values
	localparam logic [AG_W-1:0] RST_AGGR = 9'h000;
	localparam logic [PQ_W-1:0] RST_PROTO_QU = 18'h00000;
	localparam logic [RQ_W-1:0] RST_RSV_QU = 9'h000;
	localparam logic [RC_W-1:0] RST_RRA_CFG = 13'h0000;
	localparam logic [31:0] RST_RRA_WORD = 32'h00000000;
	localparam logic [CP_W-1:0] RST_CAP = 13'h0000;
	localparam logic [31:0] RST_ACT = 32'h00000000;
	localparam logic [15:0] RST_LFSR = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;

	// Frame constants
	localparam logic [47:0] RSV_BASE = 48'h0180C2000000;
	localparam logic [47:0] RSV_SPAN = 48'h00000000003F;
	localparam logic [1:0] RSV_GRP_NONE = 2'h3;
	localparam logic [23:0] V4MC_OUI = 24'h01005E;
	localparam logic [15:0] V6MC_PFX = 16'h3333;
	localparam logic [7:0] PROTO_IGMP = 8'h02;
	localparam logic [7:0] NH_HBH = 8'h00;
	localparam logic [7:0] NH_ICMP6 = 8'h3A;
	localparam logic [7:0] RA_TYPE = 8'h05;
	localparam logic [7:0] RA_LEN = 8'h02;
	localparam logic [15:0] RA_DATA = 16'h0000;
	localparam logic [23:0] V4_LOCAL = 24'hE00000;
	localparam logic [15:0] V6_LOCAL = 16'hFF02;
	localparam logic [15:0] ETYPE_RRA = 16'h8880;
	localparam logic [15:0] PROTO_ID_RRA = 16'h0004;

	typedef enum logic [1:0] {
		CACF_ACT_NONE = 2'b00,
		CACF_ACT_COPY = 2'b01,
		CACF_ACT_REDIR = 2'b10,
		CACF_ACT_DISCARD = 2'b11
	} cacf_act_type;
endpackage

/* File: src/cacf_fold.sv */
`timescale 1ns/1ps
module cacf_fold #(
	parameter int W = 468
) (
	// Contributions, already gated
	input logic [W-1:0] vec,
	// Folded code
	output logic [3:0] code
);
	logic [3:0] acc [0:W/4];

	assign acc[0] = 4'h0;
	genvar i;
	generate
		for (i = 0; i < W/4; i++) begin : g_nib
			assign acc[i+1] = acc[i] ^ vec[4*i +: 4];
		end
	endgenerate
	assign code = acc[W/4];
endmodule

/* File: src/cacf_top.sv */
`timescale 1ns/1ps
module cacf_top (
	// Clock and reset
	input logic clk_sys,
	input logic rst,
	// Wishbone slave
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Parsed frame from the parser
	input logic frm_valid,
	input logic [cacf_pkg::PORT_W-1:0] frm_port,
	input logic [47:0] frm_dmac,
	input logic [47:0] frm_smac,
	input logic frm_is_ipv4,
	input logic frm_is_ipv6,
	input logic [127:0] frm_sip,
	input logic [127:0] frm_dip,
	input logic [19:0] frm_flow_label,
	input logic frm_l4_valid,
	input logic [15:0] frm_sport,
	input logic [15:0] frm_dport,
	input logic [11:0] frm_ingress_service_index,
	input logic frm_stack_present,
	input logic [3:0] frm_stack_code,
	input logic [7:0] frm_ip_proto,
	input logic [7:0] frm_opt_type,
	input logic [7:0] frm_opt_len,
	input logic [15:0] frm_opt_data,
	input logic [1:0] frm_tag_count,
	input logic [2:0] frm_outer_tpid,
	input logic [11:0] frm_outer_vid,
	input logic [15:0] frm_etype,
	input logic [15:0] frm_proto_id,
	input logic [31:0] frm_rra_hdr,
	input logic [cacf_pkg::NPORT-1:0] frm_fwd_mask,
	input logic [cacf_pkg::NQUEUE-1:0] frm_ext_qmask,
	// Result to forwarding analyzer
	output logic res_valid,
	output logic [3:0] res_aggr_code,
	output logic [cacf_pkg::NQUEUE-1:0] res_cpu_qmask,
	output logic [cacf_pkg::NPORT-1:0] res_fwd_mask,
	output logic res_discard
);
	localparam int NP = cacf_pkg::NPORT;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = n[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [cacf_pkg::NQUEUE-1:0] qbit(input logic hit, input logic [2:0] q);
		return hit ? (cacf_pkg::NQUEUE'(1) << q) : '0;
	endfunction

	logic [cacf_pkg::AG_W-1:0] aggregation_code_config_r;
	logic [cacf_pkg::PQ_W-1:0] proto_qu_r;
	logic [cacf_pkg::RQ_W-1:0] rsv_qu_r;
	logic [cacf_pkg::RC_W-1:0] rra_cfg_r;
	logic [31:0] rra_val_r;
	logic [31:0] rra_mask_r;
	logic [cacf_pkg::CP_W-1:0] cap_r [0:NP-1];
	logic [31:0] act_r [0:NP-1][0:2];
	logic [15:0] lfsr_r;
	logic [31:0] rd_nxt;

	// Bus decode
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wb_wr = wb_req & wb_we_i;
	wire [2:0] cap_port = wb_adr_i[4:2];
	wire cap_sel = wb_adr_i[7:5] == cacf_pkg::OFS_CAP_SEL;
	wire [2:0] act_port = wb_adr_i[6:4];
	wire [1:0] act_grp = wb_adr_i[3:2];
	wire act_sel = (wb_adr_i[7] == cacf_pkg::OFS_ACT_SEL) && (act_grp != cacf_pkg::RSV_GRP_NONE);
	wire [7:0] wadr = {wb_adr_i[7:2], 2'b00};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rd_nxt : 32'h00000000;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aggregation_code_config_r <= cacf_pkg::RST_AGGR;
			proto_qu_r <= cacf_pkg::RST_PROTO_QU;
			rsv_qu_r <= cacf_pkg::RST_RSV_QU;
			rra_cfg_r <= cacf_pkg::RST_RRA_CFG;
			rra_val_r <= cacf_pkg::RST_RRA_WORD;
			rra_mask_r <= cacf_pkg::RST_RRA_WORD;
		end else if (wb_wr) begin
			if (wadr == cacf_pkg::OFS_AGGR)
				aggregation_code_config_r <= cacf_pkg::AG_W'(merge(32'(aggregation_code_config_r), wb_dat_i, wb_sel_i));
			if (wadr == cacf_pkg::OFS_PROTO_QU)
				proto_qu_r <= cacf_pkg::PQ_W'(merge(32'(proto_qu_r), wb_dat_i, wb_sel_i));
			if (wadr == cacf_pkg::OFS_RSV_QU)
				rsv_qu_r <= cacf_pkg::RQ_W'(merge(32'(rsv_qu_r), wb_dat_i, wb_sel_i));
			if (wadr == cacf_pkg::OFS_RRA_CFG)
				rra_cfg_r <= cacf_pkg::RC_W'(merge(32'(rra_cfg_r), wb_dat_i, wb_sel_i));
			if (wadr == cacf_pkg::OFS_RRA_VAL)
				rra_val_r <= merge(rra_val_r, wb_dat_i, wb_sel_i);
			if (wadr == cacf_pkg::OFS_RRA_MASK)
				rra_mask_r <= merge(rra_mask_r, wb_dat_i, wb_sel_i);
		end
	end

	// Per-port tables
	genvar p, g;
	generate
		for (p = 0; p < NP; p++) begin : g_port
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst)
					cap_r[p] <= cacf_pkg::RST_CAP;
				else if (wb_wr && cap_sel && cap_port == 3'(p))
					cap_r[p] <= cacf_pkg::CP_W'(merge(32'(cap_r[p]), wb_dat_i, wb_sel_i));
			end
			for (g = 0; g < 3; g++) begin : g_grp
				always_ff @(posedge clk_sys or posedge rst) begin
					if (rst)
						act_r[p][g] <= cacf_pkg::RST_ACT;
					else if (wb_wr && act_sel && act_port == 3'(p) && act_grp == 2'(g))
						act_r[p][g] <= merge(act_r[p][g], wb_dat_i, wb_sel_i);
				end
			end
		end
	endgenerate

	// Read mux; unmapped words read as zero
	always_comb begin
		rd_nxt = 32'h00000000;
		if (cap_sel)
			rd_nxt = 32'(cap_r[cap_port]);
		else if (act_sel)
			rd_nxt = act_r[act_port][act_grp];
		else begin
			unique case (wadr)
				cacf_pkg::OFS_AGGR: rd_nxt = 32'(aggregation_code_config_r);
				cacf_pkg::OFS_PROTO_QU: rd_nxt = 32'(proto_qu_r);
				cacf_pkg::OFS_RSV_QU: rd_nxt = 32'(rsv_qu_r);
				cacf_pkg::OFS_RRA_CFG: rd_nxt = 32'(rra_cfg_r);
				cacf_pkg::OFS_RRA_VAL: rd_nxt = rra_val_r;
				cacf_pkg::OFS_RRA_MASK: rd_nxt = rra_mask_r;
				cacf_pkg::OFS_STATUS: rd_nxt = {20'h00000, res_aggr_code, res_cpu_qmask};
				default: rd_nxt = 32'h00000000;
			endcase
		end
	end

	// Free-running pseudo-random source; advances every cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			lfsr_r <= cacf_pkg::RST_LFSR;
		else
			lfsr_r <= (lfsr_r >> 1) ^ (lfsr_r[0] ? cacf_pkg::LFSR_TAPS : 16'h0000);
	end

	// Aggregation code
	wire [cacf_pkg::AG_W-1:0] ac = aggregation_code_config_r;
	wire ip_ok = frm_is_ipv4 | frm_is_ipv6;
	wire [47:0] dmac_rev = {<<{frm_dmac}};
	wire [cacf_pkg::FOLD_W-1:0] fold_vec = {
		frm_dmac & {48{ac[cacf_pkg::AG_DMAC]}},
		dmac_rev & {48{ac[cacf_pkg::AG_DMAC_REV]}},
		frm_smac & {48{ac[cacf_pkg::AG_SMAC]}},
		frm_flow_label & {20{ac[cacf_pkg::AG_FLOW] & frm_is_ipv6}},
		{frm_sip, frm_dip} & {256{ac[cacf_pkg::AG_IP] & ip_ok}},
		{frm_sport, frm_dport} & {32{ac[cacf_pkg::AG_L4] & ip_ok & frm_l4_valid}},
		frm_ingress_service_index & {12{ac[cacf_pkg::AG_INGRESS_SERVICE_INDEX]}},
		lfsr_r[3:0] & {4{ac[cacf_pkg::AG_RND]}}
	};
	logic [3:0] fold_code;
	cacf_fold #(.W(cacf_pkg::FOLD_W)) u_fold (
		.vec(fold_vec),
		.code(fold_code)
	);
	wire use_stack = ac[cacf_pkg::AG_STACK] & frm_stack_present;
	wire [3:0] aggr_nxt = use_stack ? frm_stack_code : fold_code;

	// Capture classification
	wire [cacf_pkg::CP_W-1:0] cap = cap_r[frm_port];
	wire [4:0] tpid_dis = cap[cacf_pkg::CP_TPID +: 5];
	wire tpid_ok = (frm_tag_count == 2'd0) || !tpid_dis[frm_outer_tpid];
	wire rsv_hit = (frm_dmac & ~cacf_pkg::RSV_SPAN) == cacf_pkg::RSV_BASE;
	// Groups at 0x0x, 0x2x, 0x3x; 0x1x is left to normal forwarding
	wire [1:0] rsv_hi = frm_dmac[5:4];
	wire [1:0] rsv_grp = (rsv_hi == 2'h0) ? 2'h0 :
		((rsv_hi == 2'h1) ? cacf_pkg::RSV_GRP_NONE : rsv_hi - 2'h1);
	wire rsv_in = rsv_hit && rsv_grp != cacf_pkg::RSV_GRP_NONE;
	wire [31:0] act_word = act_r[frm_port][rsv_in ? rsv_grp : 2'd0];
	wire [1:0] rsv_act = rsv_in ? act_word[{frm_dmac[3:0], 1'b0} +: 2] : 2'b00;
	wire [2:0] rsv_qu = rsv_in ? rsv_qu_r[{rsv_grp, 1'b0} + 4'(rsv_grp) +: 3] : 3'h0;
	wire v4mac = frm_dmac[47:24] == cacf_pkg::V4MC_OUI && !frm_dmac[23];
	wire v6mac = frm_dmac[47:32] == cacf_pkg::V6MC_PFX;
	wire is_igmp = frm_ip_proto == cacf_pkg::PROTO_IGMP;
	wire nh_hbh = frm_ip_proto == cacf_pkg::NH_HBH;
	wire nh_icmp = frm_ip_proto == cacf_pkg::NH_ICMP6;
	wire ra_ok = frm_opt_type == cacf_pkg::RA_TYPE && frm_opt_len == cacf_pkg::RA_LEN &&
		frm_opt_data == cacf_pkg::RA_DATA;
	wire ev_igmp = cap[cacf_pkg::CP_IGMP] & frm_is_ipv4 & v4mac & is_igmp;
	wire ev_mld = cap[cacf_pkg::CP_MLD] & frm_is_ipv6 & v6mac & nh_hbh & ra_ok;
	wire ev_hbh = frm_is_ipv6 & ((cap[cacf_pkg::CP_HBH] & nh_hbh) |
		(cap[cacf_pkg::CP_ICMP] & nh_icmp));
	wire ev_v4mc = cap[cacf_pkg::CP_MCC] & frm_is_ipv4 & v4mac & !is_igmp &
		(frm_dip[31:8] == cacf_pkg::V4_LOCAL);
	wire ev_v6mc = cap[cacf_pkg::CP_MCC] & frm_is_ipv6 & v6mac & !nh_hbh & !nh_icmp &
		(frm_dip[127:112] == cacf_pkg::V6_LOCAL);

	// Remote register access filter; the TPID filter does not apply here
	wire rra_vlan_ok = rra_cfg_r[cacf_pkg::RC_AWARE] ?
		(frm_tag_count == 2'd1 && frm_outer_vid == rra_cfg_r[cacf_pkg::RC_VID +: 12]) :
		(frm_tag_count == 2'd0);
	wire rra_type_ok = frm_etype == cacf_pkg::ETYPE_RRA &&
		frm_proto_id == cacf_pkg::PROTO_ID_RRA;
	wire rra_hdr_ok = ((frm_rra_hdr ^ rra_val_r) & ~rra_mask_r) == 32'h00000000;
	wire rra_hit = cap[cacf_pkg::CP_RRA] & rra_vlan_ok & rra_type_ok & rra_hdr_ok;

	wire std_redir = tpid_ok & (rsv_act == cacf_pkg::CACF_ACT_REDIR | ev_igmp | ev_mld | ev_hbh);
	wire std_copy = tpid_ok & (rsv_act == cacf_pkg::CACF_ACT_COPY | ev_v4mc | ev_v6mc);
	wire disc_nxt = tpid_ok & (rsv_act == cacf_pkg::CACF_ACT_DISCARD);
	wire redir_any = std_redir | rra_hit;
	wire rsv_cpu = tpid_ok & (rsv_act[1] ^ rsv_act[0]);
	wire [cacf_pkg::NQUEUE-1:0] qmask_nxt = frm_ext_qmask
		| qbit(rsv_cpu, rsv_qu)
		| qbit(tpid_ok & ev_igmp, proto_qu_r[cacf_pkg::PQ_IGMP +: 3])
		| qbit(tpid_ok & ev_mld, proto_qu_r[cacf_pkg::PQ_MLD +: 3])
		| qbit(tpid_ok & ev_hbh, proto_qu_r[cacf_pkg::PQ_HBH +: 3])
		| qbit(tpid_ok & ev_v4mc, proto_qu_r[cacf_pkg::PQ_V4MC +: 3])
		| qbit(tpid_ok & ev_v6mc, proto_qu_r[cacf_pkg::PQ_V6MC +: 3])
		| qbit(rra_hit, proto_qu_r[cacf_pkg::PQ_RRA +: 3]);
	// Copy keeps the incoming mask; redirect and discard clear it
	wire [NP-1:0] fwd_nxt = (redir_any | disc_nxt) ? '0 : frm_fwd_mask;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			res_valid <= 1'b0;
			res_aggr_code <= 4'h0;
			res_cpu_qmask <= '0;
			res_fwd_mask <= '0;
			res_discard <= 1'b0;
		end else begin
			res_valid <= frm_valid;
			if (frm_valid) begin
				res_aggr_code <= aggr_nxt;
				res_cpu_qmask <= qmask_nxt;
				res_fwd_mask <= fwd_nxt;
				res_discard <= disc_nxt;
			end
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	AST_STACK_OVR: assert property (frm_valid && use_stack |=>
		res_aggr_code == $past(frm_stack_code)) else $error("stack code not used");
	AST_REDIR_CLEARS: assert property (frm_valid && redir_any |=>
		res_valid && res_fwd_mask == '0) else $error("redirect kept front ports");
	AST_COPY_KEEPS: assert property (frm_valid && !redir_any && !disc_nxt |=>
		res_fwd_mask == $past(frm_fwd_mask)) else $error("copy altered forwarding");
	AST_EXT_OR: assert property (frm_valid |=>
		(res_cpu_qmask & $past(frm_ext_qmask)) == $past(frm_ext_qmask)) else $error("event lost");
	AST_NO_CONTRIB: assert property (frm_valid && ac == '0 |=>
		res_aggr_code == 4'h0) else $error("code without contributions");
	AST_NON_IP: assert property (frm_valid && !ip_ok && ac[cacf_pkg::AG_IP] &&
		(ac & ~(9'h1 << cacf_pkg::AG_IP)) == '0 |=> res_aggr_code == 4'h0)
		else $error("non-IP frame changed code");
	AST_DOUBLE_TAG: assert property (frm_valid && frm_tag_count > 2'd1 |->
		!rra_hit) else $error("double tagged frame passed filter");
	AST_RRA_QUEUE: assert property (frm_valid && rra_hit |=>
		res_cpu_qmask[$past(proto_qu_r[cacf_pkg::PQ_RRA +: 3])] && res_fwd_mask == '0)
		else $error("remote access frame not redirected");
	AST_TPID_GATE: assert property (frm_valid && !tpid_ok && !rra_hit |=>
		res_cpu_qmask == $past(frm_ext_qmask) && !res_discard) else $error("filtered tag captured");
	AST_RND_MOVES: assert property (!$past(rst) |-> lfsr_r != $past(lfsr_r))
		else $error("random source stuck");
	AST_WB_ACK: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not one cycle");

	// Reserved range and protocol queue checks
	AST_RSV_GAP: assert property (frm_valid &&
		(frm_dmac & ~48'h00000000000F) == (cacf_pkg::RSV_BASE | 48'h000000000010) |->
		rsv_act == cacf_pkg::CACF_ACT_NONE) else $error("address outside groups acted on");
	AST_GARP_GROUP: assert property (frm_valid &&
		(frm_dmac & ~48'h00000000000F) == (cacf_pkg::RSV_BASE | 48'h000000000020) |->
		act_word == act_r[frm_port][1] && rsv_qu == rsv_qu_r[5:3])
		else $error("GARP group misplaced");
	AST_DISCARD: assert property (frm_valid && disc_nxt |=>
		res_discard && res_fwd_mask == '0) else $error("discard kept front ports");
	AST_RSV_COPY: assert property (frm_valid && tpid_ok &&
		rsv_act == cacf_pkg::CACF_ACT_COPY && !redir_any |=>
		res_cpu_qmask[$past(rsv_qu)] && res_fwd_mask == $past(frm_fwd_mask))
		else $error("reserved copy lost");
	AST_HBH_QUEUE: assert property (frm_valid && tpid_ok && ev_hbh |=>
		res_cpu_qmask[$past(proto_qu_r[cacf_pkg::PQ_HBH +: 3])])
		else $error("hop-by-hop queue not set");
	AST_IGMP_QUEUE: assert property (frm_valid && tpid_ok && ev_igmp |=>
		res_cpu_qmask[$past(proto_qu_r[cacf_pkg::PQ_IGMP +: 3])] && res_fwd_mask == '0)
		else $error("IGMP frame not redirected");
	AST_MC_COPY: assert property (frm_valid && tpid_ok && ev_v4mc &&
		!redir_any && !disc_nxt |=> res_fwd_mask == $past(frm_fwd_mask) &&
		res_cpu_qmask[$past(proto_qu_r[cacf_pkg::PQ_V4MC +: 3])]) else $error("control copy lost");

	COV_REDIR: cover property (frm_valid && std_redir);
	COV_COPY: cover property (frm_valid && std_copy && !redir_any);
	COV_STACK: cover property (frm_valid && use_stack);
	COV_RRA: cover property (frm_valid && rra_hit);
	COV_DISCARD: cover property (frm_valid && disc_nxt);
endmodule

/* File: sim/cacf_sink.sv */
`timescale 1ns/1ps
module cacf_sink (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Result from the classifier
	input wire logic res_valid,
	input wire logic [3:0] res_aggr_code,
	input wire logic [cacf_pkg::NQUEUE-1:0] res_cpu_qmask,
	input wire logic [cacf_pkg::NPORT-1:0] res_fwd_mask,
	input wire logic res_discard,
	// Latched result and count for the bench
	output logic [20:0] got_r,
	output logic [15:0] cnt_r
);
	// Result pulse lasts one cycle, so the analyzer side latches it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			got_r <= '0;
			cnt_r <= '0;
		end else if (res_valid) begin
			got_r <= {res_aggr_code, res_cpu_qmask, res_fwd_mask, res_discard};
			cnt_r <= cnt_r + 16'h0001;
		end
	end
endmodule

/* File: sim/classifier_aggr_code_cpu_forward_tb_top.sv */
`timescale 1ns/1ps
module classifier_aggr_code_cpu_forward_tb_top;
	localparam logic [127:0] SIP4 = 128'hC0000001, DIP4 = 128'hE0000005;
	localparam logic [127:0] SIP6 = 128'h2000_0000_0000_0000_0000_0000_0000_0001;
	localparam logic [127:0] DIP6 = 128'hFF02_0000_0000_0000_0000_0000_0000_0005;
	// Row: config, {is4,is6,stack}, expected code
	localparam logic [15:0] ROWS [16] = '{{9'h001,3'h0,4'hB}, {9'h002,3'h0,4'hD},
		{9'h003,3'h0,4'h6}, {9'h004,3'h0,4'h4}, {9'h008,3'h2,4'h2}, {9'h008,3'h4,4'h0},
		{9'h010,3'h4,4'h6}, {9'h010,3'h2,4'h4}, {9'h010,3'h0,4'h0}, {9'h020,3'h4,4'h2},
		{9'h020,3'h0,4'h0}, {9'h040,3'h0,4'h9}, {9'h17F,3'h2,4'hF}, {9'h17F,3'h3,4'h5},
		{9'h07F,3'h3,4'hF}, {9'h000,3'h0,4'h0}};
	localparam logic [39:0] CFG [9] = '{{8'h00,32'h0}, {8'h04,32'h000358D1},
		{8'h08,32'h0000008F}, {8'h48,32'h0000023F}, {8'hA0,32'h00000036},
		{8'hA4,32'h40000000}, {8'hA8,32'h00000002}, {8'h10,32'h12345678}, {8'h14,32'h000000FF}};
	// Row: low address byte, queue mask, front ports, discard
	localparam logic [24:0] RSV [6] = '{{8'h00,8'h80,8'h00,1'h0}, {8'h01,8'h80,8'hA5,1'h0},
		{8'h02,8'h00,8'h00,1'h1}, {8'h2F,8'h02,8'hA5,1'h0}, {8'h30,8'h04,8'h00,1'h0},
		{8'h10,8'h00,8'hA5,1'h0}};
	logic clk_sys = 1'h0, rst = 1'h1, cyc = 1'h0, we = 1'h0, fv = 1'h0, ack, rv, disc;
	logic [7:0] adr = 8'h00, qm, fm;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic [2:0] f_port = 3'h2, f_tpid = 3'h0;
	logic [47:0] f_dmac = 48'h800000000003, f_smac = 48'h100000000050;
	logic f_is4 = 1'h0, f_is6 = 1'h0, f_l4v = 1'h1, f_stp = 1'h0;
	logic [127:0] f_sip = 128'h0, f_dip = 128'h0;
	logic [19:0] f_fl = 20'h40006;
	logic [15:0] f_sp = 16'h1020, f_dp = 16'h0001, f_od = 16'h0, f_et = 16'h0800, f_pid = 16'h0004;
	logic [11:0] f_ingress_service_index = 12'h30A, f_vid = 12'h064;
	logic [3:0] f_stc = 4'h5, code;
	logic [7:0] f_proto = 8'h11, f_ot = 8'h05, f_ol = 8'h02, f_fwd = 8'hA5, f_ext = 8'h00;
	logic [1:0] f_tags = 2'h0;
	logic [31:0] f_hdr = 32'h123456AB;
	logic [20:0] got;
	logic [15:0] cnt, seen;
	int fails = 0, checks_done = 0, cyc_n = 0, n_sent = 0, i;

	cacf_top dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.frm_valid(fv), .frm_port(f_port), .frm_dmac(f_dmac), .frm_smac(f_smac),
		.frm_is_ipv4(f_is4), .frm_is_ipv6(f_is6), .frm_sip(f_sip), .frm_dip(f_dip),
		.frm_flow_label(f_fl), .frm_l4_valid(f_l4v), .frm_sport(f_sp), .frm_dport(f_dp),
		.frm_ingress_service_index(f_ingress_service_index), .frm_stack_present(f_stp), .frm_stack_code(f_stc),
		.frm_ip_proto(f_proto), .frm_opt_type(f_ot), .frm_opt_len(f_ol), .frm_opt_data(f_od),
		.frm_tag_count(f_tags), .frm_outer_tpid(f_tpid), .frm_outer_vid(f_vid),
		.frm_etype(f_et), .frm_proto_id(f_pid), .frm_rra_hdr(f_hdr), .frm_fwd_mask(f_fwd),
		.frm_ext_qmask(f_ext), .res_valid(rv), .res_aggr_code(code), .res_cpu_qmask(qm),
		.res_fwd_mask(fm), .res_discard(disc));
	cacf_sink sink (.clk_sys(clk_sys), .rst(rst), .res_valid(rv), .res_aggr_code(code),
		.res_cpu_qmask(qm), .res_fwd_mask(fm), .res_discard(disc), .got_r(got), .cnt_r(cnt));

	initial begin
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			fails++;
			tally_and_finish();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// Called at an edge; returns one cycle after ack so stb idles a cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		cyc <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_sys);
		while (ack !== 1'h1 && t < 20) begin
			@(posedge clk_sys);
			t++;
		end
		if (t == 20) chk("wb_ack", 32'h1, 32'h0);
		rd = rdat;
		cyc <= 1'h0;
		@(posedge clk_sys);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
		wb(1'h0, a, 32'h0);
		chk(n, e, rd);
	endtask
	task automatic pulse();
		fv <= 1'h1;
		@(posedge clk_sys);
		fv <= 1'h0;
		repeat (2) @(posedge clk_sys);
		n_sent++;
	endtask
	task automatic send(input logic [20:0] e, input string n);
		pulse();
		chk(n, {11'h0, e}, {11'h0, got});
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'h0;
		@(posedge clk_sys);
		chk("res_rst", 32'h0, {11'h0, code, qm, fm, disc});
		rchk(8'h00, 32'h0, "aggr_rst");
		rchk(8'h18, 32'h0, "status_rst");
		wb(1'h1, 8'h00, 32'hFFFFFFFF);
		rchk(8'h00, 32'h000001FF, "aggr_rw");
		wb(1'h1, 8'h04, 32'hFFFFFFFF);
		rchk(8'h04, 32'h0003FFFF, "proto_rw");
		wb(1'h1, 8'h8C, 32'hFFFFFFFF);
		rchk(8'h8C, 32'h0, "unmapped");
		$display("register test done");
		for (i = 0; i < 16; i++) begin
			wb(1'h1, 8'h00, {23'h0, ROWS[i][15:7]});
			f_is4 <= ROWS[i][6];
			f_is6 <= ROWS[i][5];
			f_stp <= ROWS[i][4];
			f_sip <= ROWS[i][5] ? SIP6 : SIP4;
			f_dip <= ROWS[i][5] ? DIP6 : DIP4;
			send({ROWS[i][3:0], 8'h00, 8'hA5, 1'h0}, "aggr");
		end
		$display("aggregation test done");
		for (i = 0; i < 9; i++) wb(1'h1, CFG[i][39:32], CFG[i][31:0]);
		f_is4 <= 1'h1;
		f_stp <= 1'h0;
		f_sip <= SIP4;
		f_dip <= DIP4;
		f_dmac <= 48'h01005E000001;
		f_proto <= 8'h02;
		f_ext <= 8'h01;
		send({4'h0, 8'h03, 8'h00, 1'h0}, "igmp");
		f_tags <= 2'h1;
		f_tpid <= 3'h1;
		send({4'h0, 8'h01, 8'hA5, 1'h0}, "tpid_off");
		f_tpid <= 3'h2;
		send({4'h0, 8'h03, 8'h00, 1'h0}, "tpid_on");
		f_tags <= 2'h0;
		f_ext <= 8'h00;
		f_proto <= 8'h11;
		f_dmac <= 48'h01005E000005;
		send({4'h0, 8'h10, 8'hA5, 1'h0}, "v4_mcc");
		f_dip <= 128'hE1000005;
		send({4'h0, 8'h00, 8'hA5, 1'h0}, "v4_far");
		f_is4 <= 1'h0;
		f_is6 <= 1'h1;
		f_sip <= SIP6;
		f_dip <= DIP6;
		f_dmac <= 48'h333300000001;
		send({4'h0, 8'h20, 8'hA5, 1'h0}, "v6_mcc");
		f_proto <= 8'h00;
		send({4'h0, 8'h0C, 8'h00, 1'h0}, "mld");
		f_od <= 16'h0001;
		send({4'h0, 8'h08, 8'h00, 1'h0}, "hbh");
		f_proto <= 8'h3A;
		f_dmac <= 48'h020000000001;
		send({4'h0, 8'h08, 8'h00, 1'h0}, "icmp6");
		f_is6 <= 1'h0;
		for (i = 0; i < 6; i++) begin
			f_dmac <= {40'h0180C20000, RSV[i][24:17]};
			send({4'h0, RSV[i][16:0]}, "rsv");
		end
		f_port <= 3'h3;
		f_dmac <= 48'h0180C2000000;
		send({4'h0, 8'h00, 8'hA5, 1'h0}, "rsv_port");
		f_port <= 3'h2;
		f_tags <= 2'h1;
		f_tpid <= 3'h1;
		f_dmac <= 48'h0180C2000001;
		send({4'h0, 8'h00, 8'hA5, 1'h0}, "rsv_tpid");
		f_tags <= 2'h0;
		f_tpid <= 3'h2;
		$display("capture test done");
		f_dmac <= 48'h020000000001;
		f_et <= 16'h8880;
		send({4'h0, 8'h40, 8'h00, 1'h0}, "rra");
		rchk(8'h18, 32'h00000040, "status");
		wb(1'h1, 8'h18, 32'hFFFFFFFF);
		rchk(8'h18, 32'h00000040, "status_ro");
		f_hdr <= 32'h023456AB;
		send({4'h0, 8'h00, 8'hA5, 1'h0}, "rra_hdr");
		f_hdr <= 32'h123456AB;
		f_pid <= 16'h0005;
		send({4'h0, 8'h00, 8'hA5, 1'h0}, "rra_pid");
		f_pid <= 16'h0004;
		f_tags <= 2'h1;
		send({4'h0, 8'h00, 8'hA5, 1'h0}, "rra_tag");
		wb(1'h1, 8'h0C, 32'h00001064);
		send({4'h0, 8'h40, 8'h00, 1'h0}, "rra_vid");
		f_vid <= 12'h065;
		send({4'h0, 8'h00, 8'hA5, 1'h0}, "rra_vid_bad");
		f_vid <= 12'h064;
		f_tags <= 2'h2;
		send({4'h0, 8'h00, 8'hA5, 1'h0}, "rra_dbl");
		f_tags <= 2'h1;
		wb(1'h1, 8'h48, 32'h0);
		send({4'h0, 8'h00, 8'hA5, 1'h0}, "rra_off");
		$display("remote access test done");
		// Random part cannot be predicted here, so only its spread is judged
		f_et <= 16'h0800;
		wb(1'h1, 8'h00, 32'h00000080);
		seen = 16'h0;
		for (i = 0; i < 8; i++) begin
			pulse();
			seen[got[20:17]] = 1'h1;
		end
		chk("rnd_spread", 32'h1, {31'h0, $countones(seen) > 1});
		chk("res_count", n_sent, {16'h0, cnt});
		rst <= 1'h1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'h0;
		@(posedge clk_sys);
		chk("res_rst2", 32'h0, {11'h0, code, qm, fm, disc});
		rchk(8'h04, 32'h0, "proto_rst2");
		$display("reset test done");
		tally_and_finish();
	end
endmodule
